//--- hdl/flash_erase_program_protect_ctrl.sv
// Purpose: flash erase/program sequencer with per-region protection
// Assumes: requests come from logic on core_clk, so no synchronisers
// Notes: protection is volatile; the permanent commit is outside this block
//
// Contract
// RULE_01: erase one 1 kB block independently
// RULE_02: erased block reads back all ones
// RULE_03: protection held per 2 kB region
// RULE_04: no-modify regions refuse erase and program
// RULE_05: fetch-only regions refuse modify and data reads
// RULE_06: program stores AND of new and old
// RULE_07: requester keeps program addresses word aligned
// RULE_08: clocks per microsecond time the pulses
// RULE_09: bad access sets access interrupt source
// RULE_10: finished operation sets done source
// RULE_11: only unmasked sources reach interrupt line
// RULE_12: raw and masked status both readable
// RULE_13: clear affects only the named sources
// RULE_14: protection takes effect immediately, volatile
// RULE_15: software clears sources early in handler
// RULE_16: protection changes only ever tighten
// RULE_17: usec setting never affects reads
// RULE_18: busy shown while an operation runs
// RULE_19: out of range requests rejected as error
`timescale 1ns/100ps
`default_nettype none
module flash_erase_program_protect_ctrl
  import flash_ctrl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // read port
  input wire read_req_type readReq,
  output logic [WORD_BITS-1:0] readData,
  output logic readValid,
  output logic readDenied,
  // erase and program requests
  input wire op_req_type opReq,
  output logic opReady,
  output logic busy,
  output logic opError,
  // protection control
  input wire logic protSet,
  input wire logic [ADDR_BITS-1:0] protAddr,
  input wire prot_type protLevel,
  output logic protSetError,
  output prot_type protRead,
  // timing
  input wire logic usecSet,
  input wire logic [USEC_BITS-1:0] usecValue,
  output logic [USEC_BITS-1:0] usecRead,
  // interrupts
  input wire logic op_done_int_mask,
  input wire logic bad_access_int_mask,
  input wire logic op_done_status_clear,
  input wire logic bad_access_status_clear,
  input wire logic status_view_select,
  output logic [1:0] intStatus,
  output logic flashInt
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  state_type state;
  op_type curOp;
  prot_type regionProt [REGION_COUNT];
  logic [WORD_ADDR_BITS-1:0] curAddr;
  logic [WORD_BITS-1:0] curData;
  logic [BLOCK_WORD_BITS-1:0] wordIdx;
  logic [15:0] pulseCnt;
  logic [1:0] rawStatus;
  logic [1:0] intMask;
  logic [WORD_BITS-1:0] memRead;
  logic memWrEn;
  logic [WORD_ADDR_BITS-1:0] memWrAddr;
  logic [WORD_BITS-1:0] memWrData;
  logic [WORD_ADDR_BITS-1:0] memRdAddr;
  logic opAccepted;
  logic opReject;
  logic readBad;
  logic readPend;
  logic [2:0] opRegion;
  logic [2:0] rdRegion;
  logic [2:0] protRegion;
  logic [15:0] pulseLen;
  logic eraseWordDone;
  logic doneEvent;

  localparam logic [15:0] ERASE_MULT = 16'(ERASE_PULSE_US);
  localparam logic [15:0] PROG_MULT = 16'(PROG_PULSE_US);

  assign opRegion = opReq.addr[REGION_SHIFT +: 3]; // see RULE_03
  assign rdRegion = readReq.addr[REGION_SHIFT +: 3];
  assign protRegion = protAddr[REGION_SHIFT +: 3];
  assign opReady = (state == ST_IDLE);
  assign busy = (state != ST_IDLE); // see RULE_18
  assign intMask = {bad_access_int_mask, op_done_int_mask};

  // ----------------------------------------
  // request checks
  // ----------------------------------------
  // the address width covers exactly the array, so the range check below never fires
  always_comb begin
    opReject = 1'b0;
    if (opReq.valid && opReady) begin
      if (opReq.op != OP_ERASE && opReq.op != OP_PROGRAM) begin
        opReject = 1'b1; // see RULE_19
      end else if (32'(opReq.addr) >= FLASH_BYTES) begin
        opReject = 1'b1; // see RULE_19
      end else if (regionProt[opRegion] != prot_full_access) begin
        opReject = 1'b1; // see RULE_04 see RULE_05
      end
    end
  end
  assign opAccepted = opReq.valid && opReady && !opReject;
  assign readBad = readReq.valid && !readReq.fetch && regionProt[rdRegion] == prot_fetch_only; // see RULE_05

  // ----------------------------------------
  // protection
  // ----------------------------------------
  // takes effect on the next cycle, volatile until reset
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      for (int i = 0; i < REGION_COUNT; i++) begin
        regionProt[i] <= prot_full_access;
      end
      protSetError <= 1'b0;
    end else begin
      protSetError <= 1'b0;
      if (protSet) begin
        if (protLevel == prot_full_access && regionProt[protRegion] == prot_full_access) begin
          protSetError <= 1'b0;
        end else if (protLevel > regionProt[protRegion] && protLevel <= prot_fetch_only) begin
          regionProt[protRegion] <= protLevel; // see RULE_14 see RULE_16
        end else if (protLevel != regionProt[protRegion]) begin
          protSetError <= 1'b1; // see RULE_16
        end
      end
    end
  end
  assign protRead = regionProt[protRegion];

  // ----------------------------------------
  // clocks per microsecond
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      usecRead <= USEC_RESET;
    end else if (usecSet) begin
      usecRead <= usecValue; // see RULE_08
    end
  end
  assign pulseLen = (curOp == OP_ERASE) ? 16'(usecRead * ERASE_MULT) : 16'(usecRead * PROG_MULT);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign eraseWordDone = (wordIdx == {BLOCK_WORD_BITS{1'b1}});
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      curOp <= OP_NONE;
      curAddr <= '0;
      curData <= '0;
      wordIdx <= '0;
      pulseCnt <= '0;
      opError <= 1'b0;
    end else begin
      opError <= opReject;
      unique case (state)
        ST_IDLE: begin
          if (opAccepted) begin
            curOp <= opReq.op;
            // erase starts at the block base so the whole 1 kB goes
            curAddr <= (opReq.op == OP_ERASE) ?
              {opReq.addr[ADDR_BITS-1:BLOCK_SHIFT], {BLOCK_WORD_BITS{1'b0}}} :
              opReq.addr[ADDR_BITS-1:2]; // see RULE_01 see RULE_07
            curData <= opReq.data;
            wordIdx <= '0;
            pulseCnt <= '0;
            state <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          // timing lasts pulseLen cycles, or one cycle when usec is zero
          if (pulseCnt + 16'h0001 >= pulseLen) begin
            state <= ST_WRITE; // see RULE_08
          end else begin
            pulseCnt <= pulseCnt + 16'h0001;
          end
        end
        ST_WRITE: begin
          if (curOp == OP_ERASE && !eraseWordDone) begin
            wordIdx <= wordIdx + 1'b1;
            curAddr <= curAddr + 1'b1;
          end else begin
            state <= ST_IDLE;
            curOp <= OP_NONE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  assign doneEvent = (state == ST_WRITE) && !(curOp == OP_ERASE && !eraseWordDone); // see RULE_10

  // ----------------------------------------
  // array access
  // ----------------------------------------
  // program waits a pulse, so the old word is already in memRead
  assign memRdAddr = (state == ST_IDLE) ? readReq.addr[ADDR_BITS-1:2] : curAddr;
  assign memWrEn = (state == ST_WRITE);
  assign memWrAddr = curAddr;
  assign memWrData = (curOp == OP_ERASE) ? ERASED_WORD : (curData & memRead); // see RULE_02 see RULE_06

  flash_array_mem u_array (
    .core_clk(core_clk),
    .readAddr(memRdAddr),
    .readData(memRead),
    .writeEn(memWrEn),
    .writeAddr(memWrAddr),
    .writeData(memWrData)
  );

  // reads do not look at usecRead at all
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      readPend <= 1'b0;
      readDenied <= 1'b0;
    end else begin
      readPend <= readReq.valid && !readBad && opReady; // see RULE_17
      readDenied <= readReq.valid && (readBad || !opReady); // see RULE_05
    end
  end
  assign readValid = readPend;
  assign readData = readPend ? memRead : '0;

  // ----------------------------------------
  // interrupt sources
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rawStatus <= 2'h0;
    end else begin
      // set wins over a clear in the same cycle
      if (doneEvent) begin
        rawStatus[INT_DONE] <= 1'b1; // see RULE_10
      end else if (op_done_status_clear) begin
        rawStatus[INT_DONE] <= 1'b0; // see RULE_13
      end
      if (readBad || opReject) begin
        rawStatus[INT_ACCESS] <= 1'b1; // see RULE_09
      end else if (bad_access_status_clear) begin
        rawStatus[INT_ACCESS] <= 1'b0; // see RULE_13
      end
    end
  end
  assign intStatus = status_view_select ? (rawStatus & intMask) : rawStatus; // see RULE_12
  assign flashInt = |(rawStatus & intMask); // see RULE_11
endmodule : flash_erase_program_protect_ctrl
`default_nettype wire

//--- hdl/flash_ctrl_pkg.sv
// Purpose: shared constants and types for the flash sequencer
// Assumes: 32-bit words, small array held in registers of a memory module
// Notes: sizes are fixed; timing figures are in microseconds
`default_nettype none
package flash_ctrl_pkg;
  localparam int WORD_BITS = 32;
  localparam int ADDR_BITS = 14;
  localparam int WORD_ADDR_BITS = ADDR_BITS - 2;
  localparam int FLASH_BYTES = 16384;
  localparam int BLOCK_WORD_BITS = 8;
  localparam int REGION_COUNT = 8;
  localparam int REGION_SHIFT = 11;
  localparam int BLOCK_SHIFT = 10;
  localparam int USEC_BITS = 8;
  localparam logic [USEC_BITS-1:0] USEC_RESET = 8'h0A;
  localparam int ERASE_PULSE_US = 4;
  localparam int PROG_PULSE_US = 2;
  localparam logic [WORD_BITS-1:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam int INT_DONE = 0;
  localparam int INT_ACCESS = 1;

  typedef enum logic [1:0] {
    prot_full_access = 2'h0,
    prot_no_modify = 2'h1,
    prot_fetch_only = 2'h2
  } prot_type;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_ERASE = 2'h1,
    OP_PROGRAM = 2'h2
  } op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_PULSE = 2'h1,
    ST_WRITE = 2'h2
  } state_type;

  typedef struct packed {
    logic valid;
    logic fetch;
    logic [ADDR_BITS-1:0] addr;
  } read_req_type;

  typedef struct packed {
    logic valid;
    op_type op;
    logic [ADDR_BITS-1:0] addr;
    logic [WORD_BITS-1:0] data;
  } op_req_type;
endpackage : flash_ctrl_pkg
`default_nettype wire

//--- hdl/flash_array_mem.sv
// Purpose: word-wide flash array storage with registered read data
// Assumes: one read port, one write port, same clock
// Notes: contents are not cleared by reset, like a real array
`timescale 1ns/100ps
`default_nettype none
module flash_array_mem
  import flash_ctrl_pkg::*;
(
  // clock
  input wire logic core_clk,
  // read port
  input wire logic [WORD_ADDR_BITS-1:0] readAddr,
  output logic [WORD_BITS-1:0] readData,
  // write port
  input wire logic writeEn,
  input wire logic [WORD_ADDR_BITS-1:0] writeAddr,
  input wire logic [WORD_BITS-1:0] writeData
);
  logic [WORD_BITS-1:0] cells [0:(1<<WORD_ADDR_BITS)-1];

  always_ff @(posedge core_clk) begin
    if (writeEn) begin
      cells[writeAddr] <= writeData;
    end
  end

  always_ff @(posedge core_clk) begin
    readData <= cells[readAddr];
  end
endmodule : flash_array_mem
`default_nettype wire

//--- tb/flash_ctrl_properties.sv
// Purpose: port-level properties of the flash sequencer
// Assumes: one clock domain, synchronous active-low reset
// Notes: raw status bits are judged only while the raw view is selected
`timescale 1ns/100ps
`default_nettype none
module flash_ctrl_properties
  import flash_ctrl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // read side
  input wire read_req_type readReq,
  input wire logic readValid,
  input wire logic readDenied,
  // operations
  input wire op_req_type opReq,
  input wire logic opReady,
  input wire logic busy,
  input wire logic opError,
  // timing
  input wire logic usecSet,
  input wire logic [USEC_BITS-1:0] usecValue,
  input wire logic [USEC_BITS-1:0] usecRead,
  // interrupts
  input wire logic op_done_int_mask,
  input wire logic status_view_select,
  input wire logic [1:0] intStatus,
  input wire logic flashInt
);
  // ----------------
  // properties
  // ----------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_busy_ready: assert property ($rose(busy) |-> $past(opReq.valid && opReady))
    else $error("busy without a taken request");
  a_fetch_served: assert property (readReq.valid && readReq.fetch && !busy |=> readValid)
    else $error("fetch read not served");
  a_read_cause: assert property (readValid || readDenied |-> $past(readReq.valid))
    else $error("read answer without request");
  a_masked_done: assert property (status_view_select && !op_done_int_mask |-> !intStatus[0])
    else $error("masked done visible");
  a_int_view: assert property (status_view_select |-> flashInt == |intStatus)
    else $error("interrupt differs from masked view");
  a_usec_load: assert property (usecSet |=> usecRead == $past(usecValue))
    else $error("usec value not loaded");
  a_op_taken: assert property (opReq.valid && opReady |=> busy || opError)
    else $error("op neither started nor refused");
  a_bad_op: assert property (opReq.valid && opReady && opReq.op == OP_NONE |=> opError && !busy)
    else $error("invalid op not refused");
  a_done_set: assert property ($fell(busy) && !status_view_select |-> ##[0:1] intStatus[0])
    else $error("done source not set");
  a_deny_access: assert property (readReq.valid && !readReq.fetch && !busy ##1 readDenied && !status_view_select
    |-> ##[0:1] intStatus[1]) else $error("denied read left no status");
endmodule : flash_ctrl_properties
bind flash_erase_program_protect_ctrl flash_ctrl_properties chk (.core_clk, .resetn, .readValid, .readDenied,
  .opReady, .busy, .opError, .readReq, .opReq, .usecSet, .op_done_int_mask, .status_view_select, .flashInt,
  .usecValue, .usecRead, .intStatus);
`default_nettype wire

//--- tb/cpu_req_model.sv
// Purpose: requester model that issues erase and program requests
// Assumes: request is held until the edge where opReady is high
// Notes: released address and data show inverted values so stale data is not trusted
`timescale 1ns/100ps
`default_nettype none
module cpu_req_model
  import flash_ctrl_pkg::*;
(
  // clock
  input wire logic core_clk,
  // command from the bench
  input wire logic go,
  input wire op_type kind,
  input wire logic [ADDR_BITS-1:0] addr,
  input wire logic [WORD_BITS-1:0] data,
  // request handshake
  input wire logic opReady,
  output op_req_type opReq = '0
);
  // ----------------
  // request hold
  // ----------------
  always_ff @(posedge core_clk) begin
    if (go) begin
      opReq <= '{1'b1, kind, {addr[ADDR_BITS-1:2], 2'b00}, data};
    end else if (opReq.valid && opReady) begin
      opReq <= '{1'b0, opReq.op, ~opReq.addr, ~opReq.data};
    end
  end
endmodule : cpu_req_model
`default_nettype wire

//--- tb/flash_erase_program_protect_ctrl_tb.sv
// Purpose: self-checking bench of the flash sequencer
// Assumes: usec set to 2 so pulses stay short
// Notes: array is not reset, so blocks are erased before use
`timescale 1ns/100ps
`default_nettype none
module flash_erase_program_protect_ctrl_tb;
  import flash_ctrl_pkg::*;
  logic core_clk = 0, resetn = 0, protSet = 0, usecSet = 0, go = 0, e;
  logic op_done_int_mask = 0, bad_access_int_mask = 0, op_done_status_clear = 0;
  logic bad_access_status_clear = 0, status_view_select = 0;
  read_req_type readReq = '0;
  op_req_type opReq;
  op_type kind = OP_NONE;
  prot_type protLevel = prot_full_access, protRead;
  logic [ADDR_BITS-1:0] protAddr = '0, addr = '0;
  logic [WORD_BITS-1:0] data = '0, readData, w, d;
  logic [USEC_BITS-1:0] usecValue = 8'h02, usecRead;
  logic readValid, readDenied, opReady, busy, opError, protSetError, flashInt;
  logic [1:0] intStatus;
  logic [31:0] seed = 32'h4D;
  int nFail = 0, nChecks = 0, nBusy = 0;
  // ----------------
  // harness
  // ----------------
  cpu_req_model cpu (.core_clk, .go, .opReady, .kind, .addr, .data, .opReq);
  flash_erase_program_protect_ctrl uut (.core_clk, .resetn, .readReq, .readData, .readValid, .readDenied,
    .opReq, .opReady, .busy, .opError, .protSet, .protAddr, .protLevel, .protSetError, .protRead,
    .usecSet, .usecValue, .usecRead, .op_done_int_mask, .bad_access_int_mask, .op_done_status_clear,
    .bad_access_status_clear, .status_view_select, .intStatus, .flashInt);
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] prog_exp(input logic [31:0] old, nw);
    return old & nw;
  endfunction : prog_exp
  task automatic chk(input string s, input logic [31:0] exp, got);
    nChecks++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", s, exp, got);
    end
  endtask : chk
  task automatic run(input op_type k, input logic [13:0] a, input logic [31:0] v);
    logic sb;
    sb = 0;
    e = 0;
    nBusy = 0;
    @(posedge core_clk);
    go <= 1;
    kind <= k;
    addr <= a;
    data <= v;
    @(posedge core_clk);
    go <= 0;
    for (int i = 0; i < 1200 && !(e || (sb && !busy)); i++) begin
      @(posedge core_clk) #1;
      sb = sb | busy;
      e = opError;
      if (busy) begin
        nBusy++;
      end
    end
    chk("op finished", 1'b1, e || (sb && !busy));
  endtask : run
  task automatic rd(input logic [13:0] a, input logic f);
    @(posedge core_clk);
    readReq <= '{1'b1, f, a};
    @(posedge core_clk);
    readReq <= '{1'b0, ~f, ~a};
    #1;
    for (int i = 0; i < 4 && !(readValid || readDenied); i++) @(posedge core_clk) #1;
    chk("read answered", 1'b1, readValid || readDenied);
  endtask : rd
  task automatic pset(input logic [13:0] a, input prot_type l, input logic ex);
    @(posedge core_clk);
    protSet <= 1;
    protAddr <= a;
    protLevel <= l;
    @(posedge core_clk);
    protSet <= 0;
    #1 chk("protSetError", ex, protSetError);
  endtask : pset
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : printVerdict
  // ----------------
  // scenarios
  // ----------------
  initial begin
    // budget is a handful of 264-cycle erases plus short ops
    repeat (20000) @(posedge core_clk);
    nFail++;
    printVerdict();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1;
    #1 chk("usecRead", 8'h0A, usecRead);
    @(posedge core_clk);
    usecSet <= 1;
    @(posedge core_clk);
    usecSet <= 0;
    #1 chk("usecRead", 8'h02, usecRead);
    run(OP_ERASE, 14'h0400, '0);
    chk("erase cycles", usecValue * ERASE_PULSE_US + (1 << BLOCK_WORD_BITS), nBusy);
    w = rnd();
    run(OP_PROGRAM, 14'h0404, w);
    chk("program cycles", usecValue * PROG_PULSE_US + 1, nBusy);
    run(OP_ERASE, 14'h0000, '0);
    rd(14'h0000, 0);
    chk("erased low", ERASED_WORD, readData);
    rd(14'h03FC, 1);
    chk("erased top", ERASED_WORD, readData);
    for (int i = 0; i < 3; i++) begin
      d = rnd();
      run(OP_PROGRAM, 14'h0404, d);
      w = prog_exp(w, d);
      rd(14'h0404, 0);
      chk("programmed", w, readData);
    end
    pset(14'h0000, prot_no_modify, 0);
    chk("protRead", prot_no_modify, protRead);
    pset(14'h07FC, prot_full_access, 1);
    run(OP_PROGRAM, 14'h0000, '0);
    chk("refused", 1'b1, e);
    rd(14'h0000, 0);
    chk("kept", ERASED_WORD, readData);
    // a fetch issued mid-erase is turned away without touching the status
    fork
      run(OP_ERASE, 14'h0800, '0);
      begin
        repeat (4) @(posedge core_clk);
        rd(14'h0000, 1);
        chk("busy read", 1'b1, readDenied);
      end
    join
    chk("other region", 1'b0, e);
    pset(14'h0000, prot_fetch_only, 0);
    run(OP_ERASE, 14'h0400, '0);
    chk("fetch-only erase", 1'b1, e);
    rd(14'h0000, 1);
    chk("fetch", 1'b1, readValid);
    rd(14'h0000, 0);
    chk("data read", 1'b1, readDenied);
    chk("raw", 2'b11, intStatus);
    @(posedge core_clk);
    status_view_select <= 1;
    op_done_int_mask <= 1;
    #1 chk("masked", 2'b01, intStatus);
    @(posedge core_clk);
    bad_access_status_clear <= 1;
    bad_access_int_mask <= 1;
    @(posedge core_clk);
    bad_access_status_clear <= 0;
    #1 chk("cleared", 2'b01, intStatus);
    @(posedge core_clk);
    op_done_int_mask <= 0;
    #1 chk("flashInt", 1'b0, flashInt);
    run(OP_NONE, 14'h0800, '0);
    chk("invalid op", 1'b1, e);
    printVerdict();
  end
endmodule : flash_erase_program_protect_ctrl_tb
`default_nettype wire
